// [core/acc_pkg.sv]
package acc_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL_A     = 8'h00;
  localparam logic [7:0] OFS_RESULT_LOW    = 8'h04;
  localparam logic [7:0] OFS_RESULT_HIGH   = 8'h08;
  localparam logic [7:0] OFS_CONTROL_B     = 8'h0C;
  localparam logic [7:0] OFS_DISABLE_LOW   = 8'h10;
  localparam logic [7:0] OFS_DISABLE_HIGH  = 8'h14;
  localparam logic [7:0] OFS_FORMAT        = 8'h18;

  // ==========================================================
  // conversion_control_a fields
  localparam int BIT_CONVERTER_ON = 7;
  localparam int BIT_START        = 6;
  localparam int BIT_AUTO_TRIG    = 5;
  localparam int BIT_DONE_FLAG    = 4;
  localparam int BIT_DONE_IRQ_ON  = 3;
  localparam int POS_DIV_SEL      = 0;

  // conversion_control_b fields
  localparam int BIT_BIPOLAR      = 7;
  localparam int POS_TRIG_SEL     = 0;

  // input_disable_high field, format register field
  localparam int POS_OFF_HIGH     = 4;
  localparam int BIT_LEFT_ALIGN   = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  localparam logic [7:0] RST_DISABLE   = 8'h00;
  localparam logic [9:0] RST_RESULT    = 10'h000;

  // ==========================================================
  // timing, in converter clock cycles, and the unipolar saturated result
  localparam logic [4:0] FIRST_CONV_CYCLES  = 5'd25;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
  localparam logic [9:0] UNIPOLAR_SATURATED = 10'h000;

  // trigger source codes
  localparam logic [2:0] TRIG_FREE_RUNNING = 3'h0;

  // ==========================================================
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FIRST = 2'b01,
    ST_CONV  = 2'b11
  } acc_state_t;

endpackage

// [core/acc_adc_control.sv]
`timescale 1ns/100ps
`default_nettype none

module acc_adc_control
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt handshake with the core
  input  wire logic        globalIrqOn,
  input  wire logic        irqVectorTaken,
  output logic             convIrq,
  // trigger flags 7..1 from peripherals, same clock
  input  wire logic [7:1]  trigFlags,
  // analog front end, asynchronous
  input  wire logic [9:0]  analogValue,
  input  wire logic        analogPosAbove,
  output logic             converterPowerOn,
  output logic             sampleActive,
  // converter pins
  input  wire logic [10:0] padIn,
  output logic      [10:0] pinInputOff,
  output logic      [10:0] portInput
);

  // ==========================================================
  // register state
  logic             onQ;
  logic             autoQ;
  logic             doneQ;
  logic             irqOnQ;
  logic [2:0]       divSelQ;
  logic             bipolarQ;
  logic [2:0]       trigSelQ;
  logic [7:0]       offLowQ;
  logic [2:0]       offHighQ;
  logic             leftAlignQ;
  logic [9:0]       result_q;
  logic             locked_q;
  acc_pkg::acc_state_t state_q;

  // ==========================================================
  // bus decode
  logic       accessDone;
  logic       wrEn;
  logic       rdEn;
  logic       mapped;
  logic [7:0] wb;

  assign accessDone = psel & penable & pready;
  assign wrEn       = accessDone & pwrite;
  assign rdEn       = accessDone & ~pwrite;
  assign wb         = pwdata[7:0];
  assign mapped     = (paddr == acc_pkg::OFS_CONTROL_A) | (paddr == acc_pkg::OFS_RESULT_LOW) |
                      (paddr == acc_pkg::OFS_RESULT_HIGH) | (paddr == acc_pkg::OFS_CONTROL_B) |
                      (paddr == acc_pkg::OFS_DISABLE_LOW) | (paddr == acc_pkg::OFS_DISABLE_HIGH) |
                      (paddr == acc_pkg::OFS_FORMAT);

  logic wrCtlA;
  assign wrCtlA = wrEn & (paddr == acc_pkg::OFS_CONTROL_A);

  // ==========================================================
  // helper functions
  function automatic logic [6:0] divLast(input logic [2:0] sel);
    logic [7:0] div;
    div = 8'h00;
    if (sel <= 3'd1)
      div = 8'h02;
    else
      div = 8'h01 << sel;
    divLast = 7'(div - 8'h01);
  endfunction

  // high or low result byte under the chosen alignment
  function automatic logic [7:0] resultByte(input logic [9:0] r, input logic la,
                                            input logic high);
    logic [7:0] b;
    b = 8'h00;
    if (la)
      b = high ? r[9:2] : {r[1:0], 6'h00};
    else
      b = high ? {6'h00, r[9:8]} : r[7:0];
    resultByte = b;
  endfunction

  // ==========================================================
  // analog input synchronisers
  logic [9:0] valMeta;
  logic [9:0] valSync;
  logic       posMeta;
  logic       posSync;
  logic [10:0] padMeta;
  logic [10:0] padSync;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valMeta <= 10'h000;
      valSync <= 10'h000;
      posMeta <= 1'b0;
      posSync <= 1'b0;
      padMeta <= 11'h000;
      padSync <= 11'h000;
    end
    else
    begin
      valMeta <= analogValue;
      valSync <= valMeta;
      posMeta <= analogPosAbove;
      posSync <= posMeta;
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  // ==========================================================
  // prescaler
  logic [6:0] preCnt;
  logic       tick;

  // divide by selected factor
  // compare is >= so a smaller divisor written mid-count cannot wrap the counter
  assign tick = onQ & (preCnt >= divLast(divSelQ));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      preCnt <= 7'h00;
    else if (!onQ || tick)
      preCnt <= 7'h00;
    else
      preCnt <= preCnt + 7'h01;
  end

  // ==========================================================
  // trigger selection
  logic trigLevel;
  logic trigPrev;
  logic doneSetEv;
  logic trigEdge;

  always_comb
  begin
    trigLevel = 1'b0;
    case (trigSelQ)
      acc_pkg::TRIG_FREE_RUNNING: trigLevel = 1'b0;
      default:                    trigLevel = trigFlags[trigSelQ];
    endcase
  end

  // rising flag edge; a switched-in set source counts
  // free-running uses completion events only, never a level edge
  assign trigEdge = (trigSelQ == acc_pkg::TRIG_FREE_RUNNING) ? doneSetEv
                                                             : (trigLevel & ~trigPrev);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      trigPrev <= 1'b0;
    else
      trigPrev <= trigLevel;
  end

  // ==========================================================
  // conversion sequencer
  logic       initPending;
  logic [4:0] cycCnt;
  logic       busy;
  logic       swStart;
  logic       autoStart;
  logic       startNow;
  logic       finish;
  logic       newOn;

  assign busy    = (state_q != acc_pkg::ST_IDLE);
  assign newOn   = wrCtlA ? wb[acc_pkg::BIT_CONVERTER_ON] : onQ;
  // a write of one starts; zero and writes while busy ignored
  assign swStart = wrCtlA & wb[acc_pkg::BIT_START] & wb[acc_pkg::BIT_CONVERTER_ON] & ~busy;
  // auto trigger only when enabled and converter on
  assign autoStart = autoQ & onQ & newOn & trigEdge & ~busy;
  assign startNow  = swStart | autoStart;
  assign finish    = tick & busy & (cycCnt == ((state_q == acc_pkg::ST_FIRST) ?
                     (acc_pkg::FIRST_CONV_CYCLES - 5'd1) :
                     (acc_pkg::NORMAL_CONV_CYCLES - 5'd1)));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      initPending <= 1'b0;
    else if (!newOn)
      initPending <= 1'b0;
    // a start in the enabling write already is the long conversion
    else if (newOn && !onQ)
      initPending <= ~startNow;
    else if (startNow)
      initPending <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= acc_pkg::ST_IDLE;
      cycCnt  <= 5'd0;
    end
    else if (!newOn)
    begin
      state_q <= acc_pkg::ST_IDLE;
      cycCnt  <= 5'd0;
    end
    else
    begin
      case (state_q)
        acc_pkg::ST_IDLE:
        begin
          cycCnt <= 5'd0;
          if (startNow)
            state_q <= (initPending || !onQ) ? acc_pkg::ST_FIRST : acc_pkg::ST_CONV;
        end
        acc_pkg::ST_FIRST, acc_pkg::ST_CONV:
        begin
          if (finish)
          begin
            state_q <= acc_pkg::ST_IDLE;
            cycCnt  <= 5'd0;
          end
          else if (tick)
            cycCnt <= cycCnt + 5'd1;
        end
        default:
          state_q <= acc_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // result capture and lock
  logic [9:0] formatted;
  logic [9:0] magnitude;

  assign magnitude = {1'b0, valSync[8:0]};

  always_comb
  begin
    formatted = valSync;
    // two's complement with sign from input polarity
    if (bipolarQ)
      formatted = posSync ? magnitude : 10'(~magnitude + 10'h001);
    // unipolar saturation when input not positive
    else if (!posSync)
      formatted = acc_pkg::UNIPOLAR_SATURATED;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      result_q <= acc_pkg::RST_RESULT;
    // frozen while the low byte has been read
    else if (finish && !locked_q)
      result_q <= formatted;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      locked_q <= 1'b0;
    else if (rdEn && paddr == acc_pkg::OFS_RESULT_HIGH)
      locked_q <= 1'b0;
    else if (rdEn && paddr == acc_pkg::OFS_RESULT_LOW)
      locked_q <= 1'b1;
  end

  // ==========================================================
  // done flag
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      doneQ     <= 1'b0;
      doneSetEv <= 1'b0;
    end
    else
    begin
      doneSetEv <= finish;
      // set on completion, winning over any clear
      if (finish)
        doneQ <= 1'b1;
      else if (irqVectorTaken || (wrCtlA && wb[acc_pkg::BIT_DONE_FLAG]))
        doneQ <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      onQ     <= acc_pkg::RST_CONTROL_A[acc_pkg::BIT_CONVERTER_ON];
      autoQ   <= acc_pkg::RST_CONTROL_A[acc_pkg::BIT_AUTO_TRIG];
      irqOnQ  <= acc_pkg::RST_CONTROL_A[acc_pkg::BIT_DONE_IRQ_ON];
      divSelQ <= acc_pkg::RST_CONTROL_A[acc_pkg::POS_DIV_SEL +: 3];
    end
    else if (wrCtlA)
    begin
      onQ     <= wb[acc_pkg::BIT_CONVERTER_ON];
      autoQ   <= wb[acc_pkg::BIT_AUTO_TRIG];
      irqOnQ  <= wb[acc_pkg::BIT_DONE_IRQ_ON];
      divSelQ <= wb[acc_pkg::POS_DIV_SEL +: 3];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bipolarQ   <= acc_pkg::RST_CONTROL_B[acc_pkg::BIT_BIPOLAR];
      trigSelQ   <= acc_pkg::RST_CONTROL_B[acc_pkg::POS_TRIG_SEL +: 3];
      offLowQ    <= acc_pkg::RST_DISABLE;
      offHighQ   <= acc_pkg::RST_DISABLE[acc_pkg::POS_OFF_HIGH +: 3];
      leftAlignQ <= 1'b0;
    end
    else if (wrEn)
    begin
      case (paddr)
        acc_pkg::OFS_CONTROL_B:
        begin
          bipolarQ <= wb[acc_pkg::BIT_BIPOLAR];
          trigSelQ <= wb[acc_pkg::POS_TRIG_SEL +: 3];
        end
        acc_pkg::OFS_DISABLE_LOW:  offLowQ    <= wb;
        acc_pkg::OFS_DISABLE_HIGH: offHighQ   <= wb[acc_pkg::POS_OFF_HIGH +: 3];
        acc_pkg::OFS_FORMAT:       leftAlignQ <= wb[acc_pkg::BIT_LEFT_ALIGN];
        default:                   leftAlignQ <= leftAlignQ;
      endcase
    end
  end

  // ==========================================================
  // read mux
  logic [7:0] rdByte;

  always_comb
  begin
    rdByte = 8'h00;
    case (paddr)
      acc_pkg::OFS_CONTROL_A:    rdByte = {onQ, busy, autoQ, doneQ, irqOnQ, divSelQ};
      acc_pkg::OFS_RESULT_LOW:   rdByte = resultByte(result_q, leftAlignQ, 1'b0);
      acc_pkg::OFS_RESULT_HIGH:  rdByte = resultByte(result_q, leftAlignQ, 1'b1);
      acc_pkg::OFS_CONTROL_B:    rdByte = {bipolarQ, 4'h0, trigSelQ};
      acc_pkg::OFS_DISABLE_LOW:  rdByte = offLowQ;
      acc_pkg::OFS_DISABLE_HIGH: rdByte = {1'b0, offHighQ, 4'h0};
      acc_pkg::OFS_FORMAT:       rdByte = {7'h00, leftAlignQ};
      default:                   rdByte = 8'h00;
    endcase
  end

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convIrq          <= 1'b0;
      converterPowerOn <= 1'b0;
      sampleActive     <= 1'b0;
      pinInputOff      <= 11'h000;
      portInput        <= 11'h000;
    end
    else
    begin
      // request needs flag, local enable and global enable
      convIrq          <= doneQ & irqOnQ & globalIrqOn & ~irqVectorTaken;
      converterPowerOn <= onQ;
      sampleActive     <= busy;
      pinInputOff      <= {offHighQ, offLowQ};
      portInput        <= padSync & ~{offHighQ, offLowQ};
    end
  end

endmodule

`default_nettype wire

// [dv/acc_adc_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module acc_adc_chk
(
  // clock, reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core, converter, pins
  input wire logic        globalIrqOn,
  input wire logic        irqVectorTaken,
  input wire logic        convIrq,
  input wire logic        converterPowerOn,
  input wire logic        sampleActive,
  input wire logic [10:0] pinInputOff,
  input wire logic [10:0] portInput
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus
  property p_rdy;
    psel && $rose(penable) |-> !pready ##1 pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not in second access cycle");
  property p_err;
    psel && penable && pready && paddr > acc_pkg::OFS_FORMAT |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access without error");
  property p_upper;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  // ==========================================================
  // converter and pins
  property p_off;
    !converterPowerOn |-> !sampleActive;
  endproperty
  a_off: assert property (p_off) else $error("converting while off");
  property p_len;
    $rose(sampleActive) |-> (sampleActive || !converterPowerOn)[*8];
  endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_irqg;
    convIrq |-> $past(globalIrqOn);
  endproperty
  a_irqg: assert property (p_irqg) else $error("irq without global enable");
  property p_vec;
    irqVectorTaken && !sampleActive |=> ##1 !convIrq;
  endproperty
  a_vec: assert property (p_vec) else $error("vector did not clear irq");
  property p_din;
    $stable(pinInputOff) |-> (portInput & pinInputOff) == 11'h000;
  endproperty
  a_din: assert property (p_din) else $error("disabled pin reads one");
  c_conv: cover property ($rose(sampleActive));
  c_irq: cover property ($rose(convIrq));
  c_err: cover property (pready && pslverr);
endmodule

bind acc_adc_control acc_adc_chk acc_adc_chk_inst
(
  .ref_clk, .rst_n, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .globalIrqOn,
  .irqVectorTaken, .convIrq, .converterPowerOn, .sampleActive, .pinInputOff, .portInput
);
`default_nettype wire

// [dv/acc_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module acc_core_model
(
  // clock
  input  wire logic        ref_clk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // ==========================================================
  // one transfer; idle edge first so calls never collide
  // control bytes written whole, never read-modify-write
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
  // low byte first, it locks the pair
  task automatic readResult(output logic [7:0] lo, output logic [7:0] hi);
    logic e;
    xfer(1'b0, acc_pkg::OFS_RESULT_LOW, 8'h00, lo, e);
    xfer(1'b0, acc_pkg::OFS_RESULT_HIGH, 8'h00, hi, e);
  endtask
  task automatic writeCtlB(input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    xfer(1'b1, acc_pkg::OFS_CONTROL_B, d & 8'hF7, r, e);
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, convIrq, converterPowerOn, sampleActive;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        globalIrqOn = 1'b0;
  logic        irqVectorTaken = 1'b0;
  logic        analogPosAbove = 1'b1;
  logic [7:1]  trigFlags = 7'h00;
  logic [9:0]  analogValue = 10'h2A5;
  logic [10:0] padIn = 11'h7FF;
  logic [10:0] pinInputOff, portInput;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycleCnt = 0;
  int          n;

  always #12.5 ref_clk = ~ref_clk;

  acc_adc_control acc_adc_control_inst
  (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .globalIrqOn, .irqVectorTaken, .convIrq, .trigFlags, .analogValue,
    .analogPosAbove, .converterPowerOn, .sampleActive, .padIn, .pinInputOff, .portInput
  );
  acc_core_model acc_core_model_inst
  (
    .ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
  );
  // ==========================================================
  // helpers
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkCnt(input string what, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    acc_core_model_inst.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    acc_core_model_inst.xfer(1'b0, a, 8'h00, r, e);
    chk(what, {3'h0, exp}, {3'h0, r});
  endtask
  task automatic res(input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] l, h;
    acc_core_model_inst.readResult(l, h);
    chk("result low", {3'h0, lo}, {3'h0, l});
    chk("result high", {3'h0, hi}, {3'h0, h});
  endtask
  // busy window length in n; zero when nothing starts
  task automatic waitConv();
    int w;
    n = 0;
    w = 0;
    while (sampleActive !== 1'b1 && w < 20)
    begin
      @(posedge ref_clk);
      w++;
    end
    while (sampleActive === 1'b1 && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task automatic conv(input logic [7:0] d);
    wr(acc_pkg::OFS_CONTROL_A, d);
    waitConv();
  endtask
  // ==========================================================
  // scenarios
  task automatic tRegs();
    logic [7:0] r;
    logic       e;
    for (int a = 0; a <= 24; a += 4)
      rdChk("reset value", 8'(a), 8'h00);
    wr(acc_pkg::OFS_RESULT_HIGH, 8'hFF);
    rdChk("read only", acc_pkg::OFS_RESULT_HIGH, 8'h00);
    acc_core_model_inst.xfer(1'b0, 8'h1C, 8'h00, r, e);
    chk("unmapped", 11'h001, {10'h000, e});
  endtask
  task automatic tConv();
    int d;
    conv(8'hC0);
    chkCnt("first conversion", 48, 52);
    chk("power on", 11'h001, {10'h000, converterPowerOn});
    rdChk("done set", acc_pkg::OFS_CONTROL_A, 8'h90);
    res(8'hA5, 8'h02);
    wr(acc_pkg::OFS_CONTROL_A, 8'h80);
    rdChk("flag kept", acc_pkg::OFS_CONTROL_A, 8'h90);
    wr(acc_pkg::OFS_CONTROL_A, 8'h90);
    rdChk("flag cleared", acc_pkg::OFS_CONTROL_A, 8'h80);
    for (int c = 0; c < 8; c++)
    begin
      d = (c < 2) ? 2 : (1 << c);
      conv(8'hD0 | 8'(c));
      chkCnt("divided conversion", 12 * d, 14 * d);
    end
    wr(acc_pkg::OFS_CONTROL_A, 8'hD7);
    rdChk("busy", acc_pkg::OFS_CONTROL_A, 8'hC7);
    wr(acc_pkg::OFS_CONTROL_A, 8'h87);
    rdChk("zero start", acc_pkg::OFS_CONTROL_A, 8'hC7);
    wr(acc_pkg::OFS_CONTROL_A, 8'h07);
    rdChk("aborted", acc_pkg::OFS_CONTROL_A, 8'h07);
  endtask
  task automatic tFormat();
    wr(acc_pkg::OFS_FORMAT, 8'h01);
    conv(8'hD0);
    res(8'h40, 8'hA9);
    wr(acc_pkg::OFS_FORMAT, 8'h00);
    acc_core_model_inst.writeCtlB(8'h80);
    analogPosAbove <= 1'b0;
    analogValue <= 10'h0A5;
    conv(8'hD0);
    res(8'h5B, 8'h03);
    acc_core_model_inst.writeCtlB(8'h00);
    conv(8'hD0);
    res(8'h00, 8'h00);
    analogPosAbove <= 1'b1;
    analogValue <= 10'h2A5;
    conv(8'hD0);
    rdChk("low locks", acc_pkg::OFS_RESULT_LOW, 8'hA5);
    analogValue <= 10'h155;
    conv(8'hD0);
    rdChk("high held", acc_pkg::OFS_RESULT_HIGH, 8'h02);
    conv(8'hD0);
    res(8'h55, 8'h01);
  endtask
  task automatic tTrig();
    acc_core_model_inst.writeCtlB(8'h01);
    wr(acc_pkg::OFS_CONTROL_A, 8'h90);
    trigFlags <= 7'h01;
    waitConv();
    chkCnt("auto off", 0, 0);
    for (int k = 1; k < 8; k++)
    begin
      trigFlags <= 7'h00;
      acc_core_model_inst.writeCtlB(8'(k));
      wr(acc_pkg::OFS_CONTROL_A, 8'hB0);
      trigFlags[k] <= 1'b1;
      waitConv();
      chkCnt("triggered", 24, 28);
    end
    trigFlags <= 7'h02;
    acc_core_model_inst.writeCtlB(8'h02);
    waitConv();
    chkCnt("select edge", 24, 28);
    trigFlags <= 7'h00;
    acc_core_model_inst.writeCtlB(8'h00);
    waitConv();
    chkCnt("free select", 0, 0);
    conv(8'hF0);
    waitConv();
    chkCnt("free restart", 24, 28);
    wr(acc_pkg::OFS_CONTROL_A, 8'h10);
    repeat (2) @(posedge ref_clk);
    waitConv();
    chkCnt("stopped", 0, 0);
    chk("power off", 11'h000, {10'h000, converterPowerOn});
  endtask
  task automatic tIrq();
    globalIrqOn <= 1'b1;
    conv(8'hC8);
    repeat (2) @(posedge ref_clk);
    chk("irq raised", 11'h001, {10'h000, convIrq});
    globalIrqOn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq masked", 11'h000, {10'h000, convIrq});
    globalIrqOn <= 1'b1;
    irqVectorTaken <= 1'b1;
    @(posedge ref_clk);
    irqVectorTaken <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", 11'h000, {10'h000, convIrq});
    rdChk("vector clears", acc_pkg::OFS_CONTROL_A, 8'h88);
  endtask
  task automatic tPins();
    wr(acc_pkg::OFS_DISABLE_LOW, 8'h0F);
    wr(acc_pkg::OFS_DISABLE_HIGH, 8'h50);
    repeat (4) @(posedge ref_clk);
    chk("pins off", 11'h50F, pinInputOff);
    chk("port input", 11'h2F0, portInput);
    rdChk("disable high", acc_pkg::OFS_DISABLE_HIGH, 8'h50);
  endtask
  // ==========================================================
  // sequence and timeout
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    tRegs();
    tConv();
    tFormat();
    tTrig();
    tIrq();
    tPins();
    end_of_test();
  end
  always @(posedge ref_clk)
  begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 40000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
endmodule
`default_nettype wire
